// file: rtl/plc_logic_cell.sv
// one programmable logic cell with an avalon-mm configuration slave
// assumes pins are asynchronous to CORE_CLK; cell clock sampled as a level
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "plc_map.svh"
module plc_logic_cell #(
  parameter int TRI_WIDTH = 4,
  parameter int CELLS_PER_GROUP = 8,
  parameter int GROUPS_PER_ROW = 36
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [3:0] DATA_IN,
  input wire logic CARRY_IN,
  input wire logic CASCADE_IN,
  input wire logic CELL_CLK,
  input wire logic GROUP_CONTROL_ONE,
  input wire logic GROUP_CONTROL_TWO,
  input wire logic DEVICE_RESET,
  input wire logic [TRI_WIDTH-1:0] TRI_DRIVE,
  input wire logic [TRI_WIDTH-1:0] TRI_ENABLE,
  output logic LOCAL_OUT,
  output logic ROW_OUT,
  output logic CARRY_OUT,
  output logic CASCADE_OUT,
  output logic TRI_BUS_OUT,
  output logic REG_Q
);

  // groups left of the ram block; the right half starts at HALF
  localparam int HALF = GROUPS_PER_ROW / 2;

  generate
    if (CELLS_PER_GROUP != 8 || GROUPS_PER_ROW < 2 || GROUPS_PER_ROW > 254
        || TRI_WIDTH < 1 || TRI_WIDTH > 32) begin : g_bad_param
      $error("plc_logic_cell: unsupported parameter value");
    end
  endgenerate

  // truth table read, shared by the arithmetic and counter tables
  function automatic logic plc_lut3(input logic [7:0] tbl, input logic [2:0] idx);
    plc_lut3 = tbl[idx];
  endfunction

  // async mode decode: {clear_n, preset_n}
  function automatic logic [1:0] plc_async(input plc_pkg::plc_async_t m,
                                           input logic c1, input logic c2,
                                           input logic ld);
    logic clr_n;
    logic pre_n;
    clr_n = 1'b1;
    pre_n = 1'b1;
    case (m)
      plc_pkg::PLC_A_CLEAR: clr_n = ~(c1 | c2);
      plc_pkg::PLC_A_PRESET: pre_n = ~c1;
      plc_pkg::PLC_A_CLRPRE: begin
        pre_n = ~c1;
        clr_n = ~c2;
      end
      plc_pkg::PLC_A_LDCLR: begin
        pre_n = ~(c1 & ld & ~c2);
        clr_n = ~((c1 & ~ld) | c2);
      end
      plc_pkg::PLC_A_LDPRE: begin
        pre_n = ~((c1 & ld) | c2);
        clr_n = ~(c1 & ~ld & ~c2);
      end
      plc_pkg::PLC_A_LOAD: begin
        pre_n = ~(c1 & ld);
        clr_n = ~(c1 & ~ld);
      end
      default: begin
        clr_n = 1'b1;
        pre_n = 1'b1;
      end
    endcase
    plc_async = {clr_n, pre_n};
  endfunction

  // configuration registers
  logic [15:0] ctrl;
  logic [15:0] lut;
  logic [10:0] chain;

  // pin synchronisers
  plc_pkg::plc_pins_t pin_s1;
  plc_pkg::plc_pins_t pin_s2;
  logic [TRI_WIDTH-1:0] drv_s1;
  logic [TRI_WIDTH-1:0] drv_s2;
  logic [TRI_WIDTH-1:0] en_s1;
  logic [TRI_WIDTH-1:0] en_s2;
  logic clk_prev;
  logic q;

  plc_pkg::plc_pins_t pin_raw;
  assign pin_raw = '{
    data: DATA_IN,
    carry_in: CARRY_IN,
    cascade_in: CASCADE_IN,
    cell_clk: CELL_CLK,
    group_control_one: GROUP_CONTROL_ONE,
    group_control_two: GROUP_CONTROL_TWO,
    device_reset: DEVICE_RESET
  };

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      drv_s1 <= '0;
      drv_s2 <= '0;
      en_s1 <= '0;
      en_s2 <= '0;
    end else if (CE) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      drv_s1 <= TRI_DRIVE;
      drv_s2 <= drv_s1;
      en_s1 <= TRI_ENABLE;
      en_s2 <= en_s1;
    end
  end

  // configuration fields
  wire plc_pkg::plc_mode_t mode = plc_pkg::plc_mode_t'(ctrl[`PLC_F_MODE +: 2]);
  wire plc_pkg::plc_async_t amode = plc_pkg::plc_async_t'(ctrl[`PLC_F_ASYNC +: 3]);
  wire plc_pkg::plc_ff_t ftype = plc_pkg::plc_ff_t'(ctrl[`PLC_F_FF +: 2]);
  wire pack_req = ctrl[`PLC_F_PACK];
  wire swap = ctrl[`PLC_F_SWAP];
  wire bypass = ctrl[`PLC_F_BYPASS];
  wire cin_sel = ctrl[`PLC_F_CINSEL];
  wire cas_or = ctrl[`PLC_F_CASOR];
  wire cas_en = ctrl[`PLC_F_CASEN];
  wire head = ctrl[`PLC_F_HEAD];
  wire devrst_en = ctrl[`PLC_F_DEVRST];
  wire rst_pre = ctrl[`PLC_F_RSTPRE];
  wire [2:0] cell_idx = chain[`PLC_F_CELL +: 3];
  wire [7:0] group_idx = chain[`PLC_F_GROUP +: 8];

  // synchronised pins
  wire [3:0] d = pin_s2.data;
  wire cin = pin_s2.carry_in;
  wire cas = pin_s2.cascade_in;
  wire c1 = pin_s2.group_control_one;
  wire c2 = pin_s2.group_control_two;
  // cell clock seen as a level; its rise shows in the same cycle as the synchronised level
  wire clk_rise = pin_s2.cell_clk & ~clk_prev;

  // chain placement: hop two groups on, stop at the row centre
  wire [7:0] half = 8'(HALF);
  wire last_cell = cell_idx == 3'(CELLS_PER_GROUP - 1);
  wire [8:0] hop = {1'b0, group_idx} + 9'h002;
  wire chain_break = last_cell &&
    ((group_idx < half && hop >= {1'b0, half}) ||
     hop >= 9'(GROUPS_PER_ROW));
  wire [7:0] next_group = last_cell ? hop[7:0] : group_idx;
  wire centre_start = cell_idx == 3'h0 &&
    (group_idx == half || group_idx == half + 8'h01);

  // cascade-in seen by this cell
  wire neutral = ~cas_or;
  wire cas_eff = (~cas_en | head | centre_start) ? neutral : cas;

  // packing only when not on a cascade chain
  wire packed_on = pack_req & ~cas_en & (mode == plc_pkg::PLC_NORMAL);
  wire pack_refused = pack_req & cas_en;

  // normal mode table
  wire sel_in = cin_sel ? cin : d[2];
  wire [3:0] idx_n = {packed_on ? 1'b0 : d[3], sel_in, d[1], d[0]};
  wire lut_n = lut[idx_n];

  // arithmetic tables: sum low half, carry high half
  wire [2:0] idx_a = {cin, d[3], d[1]};
  wire sum_a = plc_lut3(lut[7:0], idx_a);
  wire cout_a = plc_lut3(lut[15:8], idx_a);

  // counter tables: direction on cascade-in in up/down mode
  wire updown = mode == plc_pkg::PLC_UPDOWN;
  wire [2:0] idx_c = {updown ? cas : 1'b0, cin, q};
  wire cnt_tbl = plc_lut3(lut[7:0], idx_c);
  wire cout_c = plc_lut3(lut[15:8], idx_c);
  wire cnt_bit = d[1] ? cnt_tbl : q;
  wire ld_mux = d[3] ? d[2] : cnt_bit;
  wire clr_cnt = ld_mux & cas;

  // cascade combine, OR by inverting inputs and output of an AND
  wire casc_src = mode == plc_pkg::PLC_ARITH ? sum_a : lut_n;
  wire casc_and = ~(~casc_src & ~cas_eff);
  wire casc_comb = cas_or ? casc_and : (casc_src & cas_eff);

  // per-mode selection
  logic comb_o;
  logic carry_o;
  logic casc_o;
  logic reg_d;
  always_comb begin
    comb_o = lut_n;
    carry_o = 1'b0;
    casc_o = neutral;
    reg_d = lut_n;
    case (mode)
      plc_pkg::PLC_NORMAL: begin
        comb_o = lut_n;
        casc_o = casc_comb;
        reg_d = packed_on ? d[3] : lut_n;
      end
      plc_pkg::PLC_ARITH: begin
        comb_o = sum_a;
        carry_o = cout_a;
        casc_o = casc_comb;
        reg_d = sum_a;
      end
      plc_pkg::PLC_UPDOWN: begin
        comb_o = cnt_tbl;
        carry_o = cout_c;
        reg_d = ld_mux;
      end
      plc_pkg::PLC_CLRCNT: begin
        comb_o = cnt_tbl;
        carry_o = cout_c;
        reg_d = clr_cnt;
      end
      default: begin
        comb_o = lut_n;
        carry_o = 1'b0;
        casc_o = neutral;
        reg_d = lut_n;
      end
    endcase
  end

  // flip-flop personality; second operand from the second data line
  logic ff_next;
  always_comb begin
    ff_next = reg_d;
    case (ftype)
      plc_pkg::PLC_FF_D: ff_next = reg_d;
      plc_pkg::PLC_FF_T: ff_next = q ^ reg_d;
      plc_pkg::PLC_FF_JK: ff_next = (reg_d & ~q) | (~d[1] & q);
      plc_pkg::PLC_FF_SR: ff_next = reg_d | (~d[1] & q);
      default: ff_next = reg_d;
    endcase
  end

  // asynchronous controls and device reset
  wire [1:0] ctl_n = plc_async(amode, c1, c2, d[2]);
  wire clear_n = ctl_n[1];
  wire preset_n = ctl_n[0];
  wire has_pre = amode == plc_pkg::PLC_A_PRESET || amode == plc_pkg::PLC_A_CLRPRE ||
                 amode == plc_pkg::PLC_A_LDPRE;
  wire dev_rst = devrst_en & pin_s2.device_reset;
  wire rst_val = rst_pre & has_pre;

  // priority: device reset, clear, preset, then the cell clock
  logic next_q;
  always_comb begin
    next_q = q;
    if (dev_rst) begin
      next_q = rst_val;
    end else if (!clear_n) begin
      next_q = 1'b0;
    end else if (!preset_n) begin
      next_q = 1'b1;
    end else if (clk_rise && d[0]) begin
      next_q = ff_next;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      q <= 1'b0;
      clk_prev <= 1'b0;
    end else if (CE) begin
      q <= next_q;
      clk_prev <= pin_s2.cell_clk;
    end
  end

  // output steering
  wire reg_view = bypass ? comb_o : next_q;
  wire next_local = packed_on ? (swap ? next_q : lut_n) : reg_view;
  wire next_row = packed_on ? (swap ? lut_n : next_q) : reg_view;

  // emulated tri-state bus
  logic [TRI_WIDTH-1:0] drv_on;
  genvar gi;
  generate
    for (gi = 0; gi < TRI_WIDTH; gi++) begin : g_tri
      assign drv_on[gi] = drv_s2[gi] & en_s2[gi];
    end
  endgenerate
  // contention resolves low, an idle bus reads high
  wire any_en = |en_s2;
  wire multi_en = |(en_s2 & (en_s2 - 1'b1));
  wire next_tri = multi_en ? 1'b0 : (any_en ? |drv_on : 1'b1);

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      LOCAL_OUT <= 1'b0;
      ROW_OUT <= 1'b0;
      CARRY_OUT <= 1'b0;
      CASCADE_OUT <= 1'b1;
      TRI_BUS_OUT <= 1'b1;
      REG_Q <= 1'b0;
    end else if (CE) begin
      LOCAL_OUT <= next_local;
      ROW_OUT <= next_row;
      CARRY_OUT <= carry_o;
      CASCADE_OUT <= casc_o;
      TRI_BUS_OUT <= next_tri;
      REG_Q <= next_q;
    end
  end

  // avalon slave: waitrequest drops one cycle after the request
  logic ack;
  wire req = AVS_READ | AVS_WRITE;
  wire hit_ctrl = AVS_ADDRESS == `PLC_ADDR_CTRL;
  wire hit_lut = AVS_ADDRESS == `PLC_ADDR_LUT;
  wire hit_chain = AVS_ADDRESS == `PLC_ADDR_CHAIN;
  wire hit_stat = AVS_ADDRESS == `PLC_ADDR_STATUS;
  // a write lands on the edge after the one that drops waitrequest
  wire wr_go = AVS_WRITE & ack;
  // status from q up to the next group; upper bits read zero
  wire [31:0] status = {17'h00000, next_group, chain_break, pack_refused,
                        CASCADE_OUT, CARRY_OUT, ROW_OUT, LOCAL_OUT, q};
  // read data latched on the taking edge, held through the answer
  wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl} :
                       hit_lut ? {16'h0000, lut} :
                       hit_chain ? {21'h000000, chain} :
                       hit_stat ? status : 32'h00000000;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ack <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h00000000;
    end else if (CE) begin
      ack <= req & ~ack;
      AVS_WAITREQUEST <= ~(req & ~ack);
      if (AVS_READ && !ack) begin
        AVS_READDATA <= rd_mux;
      end
    end
  end

  // configuration writes; tables change only by software
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl <= `PLC_CTRL_RST;
      lut <= `PLC_LUT_RST;
      chain <= `PLC_CHAIN_RST;
    end else if (CE && wr_go) begin
      // status and unmapped offsets ignore writes
      if (hit_ctrl) begin
        ctrl <= AVS_WRITEDATA[15:0];
      end
      if (hit_lut) begin
        lut <= AVS_WRITEDATA[15:0];
      end
      if (hit_chain) begin
        chain <= AVS_WRITEDATA[10:0];
      end
    end
  end

endmodule // plc_logic_cell

// file: shared/plc_map.svh
// register offsets, field positions, reset values of the logic cell
// assumes byte addressing on a 4-bit avalon address, one word a register
// Overview of operation
// - cascade joins lookup output with cascade-in by AND, or by OR via inversion
// - every chained cell adds four inputs, n cells give 4n variables
// - chains past eight cells hop to the group two further along the row
// - a chain stops at the row centre; a new chain starts beyond it
// - four modes: normal, arithmetic, up/down counter, clearable counter
// - seven steered inputs plus clock, clear and preset controls
// - first data line is a synchronous clock enable in every mode
// - normal mode: four-input table, carry-in or third data line selectable
// - packed: fourth data line feeds register, table does three-input function
// - packed register keeps clock enable, clear and preset
// - no packing while the cell sits in a cascade chain
// - arithmetic: two three-input tables give sum and carry-out
// - arithmetic mode may use cascade and carry chains together
// - up/down counter: enable, direction, 2-to-1 load mux, count and carry tables
// - counters load asynchronously through clear and preset
// - clearable counter: synchronous clear replaces direction, ANDed after load mux
// - emulated tri-state: contention gives low, no driver gives high
// - async control from third data line and both group controls
// - clear and preset act low; unused ones held high
// - six asynchronous modes selected at configuration
// - enabled device reset sets the cell register to its reset value, above all other controls
// - preset-capable register may go to one on device reset
// - clear plus preset: control one presets, control two clears
// - register acts as D, T, JK or SR flip-flop, or is bypassed
`ifndef PLC_MAP_SVH
`define PLC_MAP_SVH
`define PLC_ADDR_CTRL 4'h0
`define PLC_ADDR_LUT 4'h4
`define PLC_ADDR_CHAIN 4'h8
`define PLC_ADDR_STATUS 4'hC
`define PLC_F_MODE 0
`define PLC_F_ASYNC 2
`define PLC_F_FF 5
`define PLC_F_PACK 7
`define PLC_F_SWAP 8
`define PLC_F_BYPASS 9
`define PLC_F_CINSEL 10
`define PLC_F_CASOR 11
`define PLC_F_CASEN 12
`define PLC_F_HEAD 13
`define PLC_F_DEVRST 14
`define PLC_F_RSTPRE 15
`define PLC_F_CELL 0
`define PLC_F_GROUP 3
`define PLC_CTRL_RST 16'h0000
`define PLC_LUT_RST 16'h0000
`define PLC_CHAIN_RST 11'h000
`endif

// file: shared/plc_pkg.sv
// types shared by the logic cell and its bench
// assumes plc_map.svh for numeric constants
package plc_pkg;
  typedef enum logic [1:0] {
    PLC_NORMAL, PLC_ARITH, PLC_UPDOWN, PLC_CLRCNT
  } plc_mode_t;
  typedef enum logic [2:0] {
    PLC_A_CLEAR, PLC_A_PRESET, PLC_A_CLRPRE, PLC_A_LDCLR, PLC_A_LDPRE, PLC_A_LOAD
  } plc_async_t;
  typedef enum logic [1:0] {
    PLC_FF_D, PLC_FF_T, PLC_FF_JK, PLC_FF_SR
  } plc_ff_t;
  typedef struct packed {
    logic [3:0] data;
    logic carry_in;
    logic cascade_in;
    logic cell_clk;
    logic group_control_one;
    logic group_control_two;
    logic device_reset;
  } plc_pins_t;
endpackage

// file: bench/plc_cell_monitor.sv
// port checker for the logic cell
// bound to plc_logic_cell; shadows the control word from bus writes
`timescale 1ns/1ps
module plc_cell_monitor #(
  parameter int TRI_WIDTH = 4
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [3:0] DATA_IN,
  input wire logic GROUP_CONTROL_ONE,
  input wire logic GROUP_CONTROL_TWO,
  input wire logic DEVICE_RESET,
  input wire logic [TRI_WIDTH-1:0] TRI_ENABLE,
  input wire logic TRI_BUS_OUT,
  input wire logic REG_Q
);
  logic [15:0] ctrl;
  wire [2:0] am = ctrl[4:2];
  wire drst = ctrl[14] && DEVICE_RESET;
  wire g1 = GROUP_CONTROL_ONE;
  wire g2 = GROUP_CONTROL_TWO;
  wire calm = !g1 && !g2 && !drst;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  always_ff @(posedge CORE_CLK) begin
    if (RST)
      ctrl <= 16'h0000;
    else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0)
      ctrl <= AVS_WRITEDATA[15:0];
  end
  chk_tri_contend: assert property (($countones(TRI_ENABLE) > 1)[*5] |-> !TRI_BUS_OUT)
    else $error("tri bus not low under contention");
  chk_tri_float: assert property ((TRI_ENABLE == '0)[*5] |-> TRI_BUS_OUT)
    else $error("tri bus not high without driver");
  chk_clear_either: assert property ((am == 3'h0 && (g1 || g2))[*5] |-> !REG_Q)
    else $error("clear mode did not clear");
  chk_pair_preset: assert property ((am == 3'h2 && g1 && !g2 && !drst)[*5] |-> REG_Q)
    else $error("control one did not preset");
  chk_pair_clear: assert property ((am == 3'h2 && g2)[*5] |-> !REG_Q)
    else $error("control two did not clear");
  chk_load_value: assert property ((am inside {3'h3, 3'h5} && g1 && !g2 && !drst
    && $stable(DATA_IN[2]))[*5] |-> REG_Q == DATA_IN[2])
    else $error("async load value not taken");
  chk_devrst_wins: assert property ((drst && !ctrl[15])[*5] |-> !REG_Q)
    else $error("device reset did not clear");
  chk_hold_disabled: assert property ((calm && !DATA_IN[0])[*6] |-> $stable(REG_Q))
    else $error("register moved while disabled");
endmodule // plc_cell_monitor

// file: bench/plc_neighbour.sv
// upstream neighbour: group clock and cascade-in for the cell
// assumes the bench supplies the remaining pins through drive
`timescale 1ns/1ps
module plc_neighbour (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] up_table,
  input wire logic [3:0] up_data,
  input wire plc_pkg::plc_pins_t drive,
  output plc_pkg::plc_pins_t pins
);
  logic [2:0] div;
  always_ff @(posedge clk) begin
    if (rst)
      div <= 3'h0;
    else
      div <= div + 3'h1;
  end
  always_comb begin
    pins = drive;
    pins.cell_clk = div[2];
    pins.cascade_in = up_table[up_data];
  end
endmodule // plc_neighbour

// file: bench/plc_logic_cell_test.sv
// self-checking bench: bus, packing, cascade, arithmetic, async, chain, tri bus
// assumes plc_neighbour makes the cell clock (8 cycles) and cascade-in
`timescale 1ns/1ps
module plc_logic_cell_test;
  localparam logic [2:0] MODES [3] = '{3'h5, 3'h0, 3'h3};
  localparam logic [7:0] GS [8] = '{8'h00, 8'h10, 8'h0F, 8'h11, 8'h21, 8'h22, 8'h01, 8'h12};
  logic clk, rst, rd, wr, wait_req, b, ci, ce, j, k;
  logic [3:0] addr, tdrv, ten, up_data;
  logic [31:0] wdata, rdata, q;
  logic [15:0] lut, up_table;
  logic [7:0] g;
  logic [2:0] c;
  plc_pkg::plc_pins_t d, pins;
  logic local_out, row_out, carry_out, cas_out, tri_out, reg_q;
  int errors, check_count;
  plc_neighbour plc_neighbour_inst (.clk(clk), .rst(rst), .up_table(up_table),
    .up_data(up_data), .drive(d), .pins(pins));
  plc_logic_cell plc_logic_cell_inst (.CORE_CLK(clk), .RST(rst), .CE(ce),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .DATA_IN(pins.data),
    .CARRY_IN(pins.carry_in), .CASCADE_IN(pins.cascade_in), .CELL_CLK(pins.cell_clk),
    .GROUP_CONTROL_ONE(pins.group_control_one), .GROUP_CONTROL_TWO(pins.group_control_two),
    .DEVICE_RESET(pins.device_reset), .TRI_DRIVE(tdrv), .TRI_ENABLE(ten),
    .LOCAL_OUT(local_out), .ROW_OUT(row_out), .CARRY_OUT(carry_out),
    .CASCADE_OUT(cas_out), .TRI_BUS_OUT(tri_out), .REG_Q(reg_q));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= v;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 40);
    if (wait_req !== 1'b0) begin
      errors++;
      close_out();
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // three cell clock periods: a captured edge plus pin latency
  task automatic settle;
    repeat (24) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    tdrv = 4'h0;
    ten = 4'h0;
    up_table = 16'hFFFF;
    up_data = 4'h0;
    d = '0;
    b = 1'b0;
    errors = 0;
    check_count = 0;
    void'($urandom(23));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i += 2) begin
      bus(1'b0, i[3:0], 32'h0);
      check(q, 32'h0);
    end
    bus(1'b1, 4'hA, 32'hFFFF_FFFF);
    bus(1'b0, 4'hA, 32'h0);
    check(q, 32'h0);
    lut = 16'($urandom);
    bus(1'b1, 4'h4, {16'hFFFF, lut});
    bus(1'b0, 4'h4, 32'h0);
    check(q, {16'h0, lut});
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 4'h0, {23'h0, i[2], 8'h80});
      d.data <= 4'($urandom);
      settle();
      if (d.data[0])
        b = d.data[3];
      check(reg_q, b);
      check(i[2] ? local_out : row_out, b);
      check(i[2] ? row_out : local_out, lut[{1'b0, d.data[2:0]}]);
    end
    bus(1'b1, 4'h0, 32'h1080);
    bus(1'b0, 4'hC, 32'h0);
    check(q[5], 1'b1);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 4'h0, {18'h0, i[1], 1'b1, i[0], 11'h0});
      d.data <= 4'($urandom);
      up_table <= 16'($urandom);
      up_data <= 4'($urandom);
      settle();
      b = lut[d.data];
      ci = up_table[up_data];
      check(cas_out, i[1] ? b : (i[0] ? b | ci : b & ci));
    end
    bus(1'b1, 4'h4, 32'hE896);
    bus(1'b1, 4'h0, 32'h1201);
    for (int i = 0; i < 8; i++) begin
      d.data <= 4'($urandom);
      d.carry_in <= i[0];
      settle();
      b = d.data[1] ^ d.data[3];
      check(local_out, b ^ d.carry_in);
      check(carry_out, (d.data[1] & d.data[3]) | (d.carry_in & b));
    end
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 4'h0, {27'h0, MODES[i], 2'h0});
      d.data[2] <= (i == 0) ? 1'b1 : 1'($urandom);
      d.group_control_one <= 1'b1;
      settle();
      check(reg_q, (MODES[i] == 3'h0) ? 1'b0 : d.data[2]);
      d.group_control_one <= 1'b0;
    end
    bus(1'b1, 4'h0, 32'h4008);
    d.group_control_one <= 1'b1;
    settle();
    check(reg_q, 1'b1);
    d.device_reset <= 1'b1;
    settle();
    check(reg_q, 1'b0);
    d.device_reset <= 1'b0;
    d.group_control_two <= 1'b1;
    settle();
    check(reg_q, 1'b0);
    d.group_control_one <= 1'b0;
    d.group_control_two <= 1'b0;
    // counters: load phase, then carry table with capture blocked
    lut = 16'($urandom);
    d.data[0] <= 1'b0;
    bus(1'b1, 4'h4, {16'h0000, lut});
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 4'h0, {30'h0, 1'b1, i[0]});
      j = 1'($urandom);
      d.data <= {1'b1, j, 1'b0, 1'b1};
      d.carry_in <= 1'($urandom);
      up_table <= 16'($urandom);
      up_data <= 4'($urandom);
      settle();
      ci = up_table[up_data];
      b = j & (ci | !i[0]);
      check(reg_q, b);
      d.data <= {1'b0, j, 1'b1, 1'b0};
      settle();
      check(carry_out, lut[{1'b1, ci & !i[0], d.carry_in, b}]);
    end
    // flip-flop personalities; table output follows the fourth data line
    bus(1'b1, 4'h4, 32'h0000_FF00);
    for (int i = 0; i < 8; i++) begin
      j = (i[1:0] == 2'h1) ? 1'b0 : 1'($urandom);
      k = 1'($urandom) & !j;
      d.data[0] <= 1'b0;
      bus(1'b1, 4'h0, {25'h0, i[1:0], 5'h00});
      d.data <= {j, 1'b0, k, 1'b1};
      settle();
      b = (j || i[1:0] == 2'h0) ? j : ((k && i[1]) ? 1'b0 : b);
      check(reg_q, b);
    end
    for (int i = 0; i < 12; i++) begin
      g = (i < 8) ? GS[i] : 8'($urandom % 36);
      c = i[0] ? 3'h7 : 3'($urandom % 7);
      bus(1'b1, 4'h8, {21'h0, g, c});
      bus(1'b0, 4'hC, 32'h0);
      b = (c == 3'h7) && ((g < 8'h12 && g + 8'h2 >= 8'h12) || g + 8'h2 >= 8'h24);
      check(q[6], b);
      if (!b)
        check(q[14:7], (c == 3'h7) ? g + 8'h2 : g);
    end
    for (int i = 0; i < 10; i++) begin
      ten <= (i < 2) ? {4{i[0]}} : 4'($urandom);
      tdrv <= 4'($urandom);
      settle();
      check(tri_out, ($countones(ten) > 1) ? 1'b0 : (ten == 4'h0 ? 1'b1 : |(tdrv & ten)));
    end
    // clock enable low freezes the synchronisers and the outputs
    ten <= 4'h1;
    tdrv <= 4'h0;
    settle();
    check(tri_out, 1'b0);
    ce <= 1'b0;
    tdrv <= 4'h1;
    settle();
    check(tri_out, 1'b0);
    ce <= 1'b1;
    settle();
    check(tri_out, 1'b1);
    close_out();
  end
endmodule // plc_logic_cell_test
bind plc_logic_cell plc_cell_monitor #(.TRI_WIDTH(TRI_WIDTH)) plc_cell_monitor_inst (
  .CORE_CLK(CORE_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .DATA_IN(DATA_IN),
  .GROUP_CONTROL_ONE(GROUP_CONTROL_ONE), .GROUP_CONTROL_TWO(GROUP_CONTROL_TWO),
  .DEVICE_RESET(DEVICE_RESET), .TRI_ENABLE(TRI_ENABLE), .TRI_BUS_OUT(TRI_BUS_OUT),
  .REG_Q(REG_Q));
